// ==== scope_cfg.svh ====
// scope_cfg.svh: register offsets, field positions, reset values and sizes
// assumes: included by bare name from each design file that needs it
`ifndef SCOPE_CFG_SVH
`define SCOPE_CFG_SVH
`define ADDR_W 12
`define OFS_CTRL 12'h000
`define OFS_LEVEL 12'h004
`define OFS_HYST 12'h008
`define OFS_SRC0 12'h00C
`define OFS_SRC1 12'h010
`define OFS_LIM0 12'h014
`define OFS_LIM1 12'h018
`define OFS_SPAN0 12'h01C
`define OFS_OFFS0 12'h020
`define OFS_SPAN1 12'h024
`define OFS_OFFS1 12'h028
`define OFS_STATUS 12'h02C
`define OFS_STREAM 12'h030
`define CTRL_GATE_EN 0
`define CTRL_GATE_SEL 1
`define CTRL_EDGE 3
`define CTRL_HKIND 5
`define CTRL_RATE 8
`define CTRL_STREN 12
`define CTRL_DROP 14
`define STAT_ARMED 0
`define STAT_GATE 1
`define STAT_OPTION 2
`define STAT_AVAIL 3
`define STAT_OVF 4
`define STREAM_CHAN 16
`define STREAM_VALID 31
`define RST_CTRL 32'h0000_0000
`define RST_LEVEL 16'h0000
`define RST_HYST 32'h0000_0000
`define RST_SRC 8'h00
`define RST_LIM 32'h7FFF_8000
`define SAMPLE_HIGH 16'h7FFF
`define FRAC_SHIFT 8
`define NUM_SRC 67
`define FIFO_DEPTH 8
`define WORD_W 17
`endif

// ==== scope_pkg.sv ====
// scope_pkg: types shared by the scope front-end files
// assumes: nothing outside itself
package scope_pkg;
    typedef logic signed [15:0] sample_t;
    typedef logic [7:0] src_code_t;
    typedef enum logic [1:0] {EDGE_NONE = 2'h0, EDGE_RISE = 2'h1, EDGE_FALL = 2'h2, EDGE_BOTH = 2'h3} edge_t;
    typedef enum logic {ARM_ST = 1'b0, HOLD_ST = 1'b1} arm_state_t;
endpackage : scope_pkg

// ==== stream_if.sv ====
// stream_if: valid/ready word carrier between the top and its fifo
// assumes: one clock shared by both ends
`timescale 1ns/1ns
interface stream_if #(parameter int W = 17);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface : stream_if

// ==== scope_mem.sv ====
// scope_mem: small word memory with registered read and write-through
// assumes: one write and one read port on the same clock
`timescale 1ns/1ns
module scope_mem #(parameter int WIDTH = 17, parameter int DEPTH = 8, parameter int AW = 3) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] store [DEPTH];
    // bypass so a word written into an empty fifo shows up one cycle later
    wire bypass = we_in && (waddr_in == raddr_in);

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            store[waddr_in] <= wdata_in;
        end
        rdata_out <= bypass ? wdata_in : store[raddr_in];
    end
endmodule : scope_mem

// ==== scope_fifo.sv ====
// scope_fifo: show-ahead fifo, width and depth set by parameters
// assumes: synchronous active-high reset; depth a power of two
`timescale 1ns/1ns
module scope_fifo #(parameter int WIDTH = 17, parameter int DEPTH = 8) (
    input wire logic clk_in,
    input wire logic rst_in,
    stream_if.sink wr,
    stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    wire full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    wire empty = (wptr_q == rptr_q);
    wire push = wr.valid && !full;
    wire pop = rd.valid && rd.ready;
    wire [AW:0] rptr_d = pop ? rptr_q + 1'b1 : rptr_q;

    assign wr.ready = !full;
    assign rd.valid = !empty;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= push ? wptr_q + 1'b1 : wptr_q;
            rptr_q <= rptr_d;
        end
    end

    scope_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk_in(clk_in),
        .we_in(push),
        .waddr_in(wptr_q[AW-1:0]),
        .wdata_in(wr.data),
        .raddr_in(rptr_d[AW-1:0]),
        .rdata_out(rd.data)
    );
endmodule : scope_fifo

// ==== scope_trigger_channel_select.sv ====
// scope_trigger_channel_select: trigger gating and hysteresis, two channel source muxes,
// averaging or decimation, per-channel streaming through a fifo read over APB
// assumes: sources are synchronous to CLK_SYS_IN and qualified by SAMPLE_VALID_IN;
// trigger pins and the option strap are asynchronous
// Notes on behaviour
// - gating on with digitizer option: trigger only at qualifying level
// - gate select: in3 high/low, in4 high/low
// - rearm only after leaving level by hysteresis
// - hysteresis kind: absolute or fraction of span
// - fraction is 8.8 fixed, above one allowed
// - reduced rate: zero averages, one decimates
// - codes 0-9: inputs, triggers, aux ports
// - codes 16-71: demodulator x, y, r, phase
// - loop value, shift, error codes
// - boxcar, cartesian and polar arithmetic codes
// - waveform markers and triggers codes
// - per-channel streaming enable, independent of trigger
// - readable stream register, needs digitizer option
// - per-channel floor and ceiling limits
// - report span and offset per channel
// - edge select: none, rising, falling, both
`timescale 1ns/1ns
`include "scope_cfg.svh"
module scope_trigger_channel_select (
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    input wire logic [`ADDR_W-1:0] PADDR_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic SAMPLE_VALID_IN,
    input wire logic [31:0] SIGIN_IN,
    input wire logic [3:0] TRIG_PIN_IN,
    input wire logic [63:0] AUXOUT_IN,
    input wire logic [31:0] AUXIN_IN,
    input wire logic [127:0] DEMOD_X_IN,
    input wire logic [127:0] DEMOD_Y_IN,
    input wire logic [127:0] DEMOD_R_IN,
    input wire logic [127:0] DEMOD_PHASE_IN,
    input wire logic [63:0] LOOP_VALUE_IN,
    input wire logic [63:0] LOOP_SHIFT_IN,
    input wire logic [63:0] LOOP_ERROR_IN,
    input wire logic [31:0] BOXCAR_IN,
    input wire logic [31:0] ARITH_CART_IN,
    input wire logic [15:0] ARITH_POLAR_IN,
    input wire logic [3:0] AWG_MARKER_IN,
    input wire logic [3:0] AWG_TRIG_IN,
    input wire logic DIGITIZER_OPTION_IN,
    output logic TRIG_OUT,
    output logic TRIG_ARMED_OUT
);
    // {known, needs option, dense index}
    function automatic logic [8:0] src_lookup(input logic [7:0] c);
        logic [3:0] lim;
        logic [6:0] base;
        logic ok;
        lim = 4'h0;
        base = 7'h00;
        ok = 1'b1;
        case (c[7:4])
            4'h0: begin lim = 4'h9; base = 7'h00; end
            4'h1: begin lim = 4'h7; base = 7'h0A; end
            4'h2: begin lim = 4'h7; base = 7'h12; end
            4'h3: begin lim = 4'h7; base = 7'h1A; end
            4'h4: begin lim = 4'h7; base = 7'h22; end
            4'h5: begin lim = 4'h3; base = 7'h2A; end
            4'h6: begin lim = 4'h1; base = 7'h2E; end
            4'h7: begin lim = 4'h1; base = 7'h30; end
            4'h8: begin lim = 4'h0; base = 7'h32; end
            4'h9: begin lim = 4'h3; base = 7'h33; end
            4'hB: begin lim = 4'h3; base = 7'h37; end
            4'hC: begin lim = 4'h3; base = 7'h3B; end
            4'hD: begin lim = 4'h3; base = 7'h3F; end
            // reserved and unlisted codes select nothing and read zero
            default: begin ok = 1'b0; end
        endcase
        ok = ok && (c[3:0] <= lim);
        src_lookup = {ok, (c[7:4] != 4'h0) || (c[3:2] == 2'b01), 7'(base + {3'h0, c[3:0]})};
    endfunction : src_lookup

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        strb_merge = (old & ~m) | (wd & m);
    endfunction : strb_merge

    // pin synchronisers; first stage is read only by the second
    logic [4:0] pin_m_q;
    logic [4:0] pin_s_q;
    always_ff @(posedge CLK_SYS_IN) begin
        pin_m_q <= {DIGITIZER_OPTION_IN, TRIG_PIN_IN};
        pin_s_q <= pin_m_q;
    end
    wire [3:0] trig_s = pin_s_q[3:0];
    wire option = pin_s_q[4];

    // registers
    logic [31:0] ctrl_q;
    logic [15:0] level_q;
    logic [31:0] hyst_q;
    logic [7:0] code_q [2];
    logic [31:0] lim_q [2];
    logic ovf_q;
    logic [31:0] prdata_q;
    logic err_q;

    wire setup = PSEL_IN && !PENABLE_IN;
    wire access = PSEL_IN && PENABLE_IN;
    wire wr_en = access && PWRITE_IN;
    wire gate_en = ctrl_q[`CTRL_GATE_EN];
    wire [1:0] gate_sel = ctrl_q[`CTRL_GATE_SEL +: 2];
    wire scope_pkg::edge_t edge_sel = scope_pkg::edge_t'(ctrl_q[`CTRL_EDGE +: 2]);
    wire hyst_kind = ctrl_q[`CTRL_HKIND];
    wire [3:0] rate = ctrl_q[`CTRL_RATE +: 4];
    wire [15:0] hyst_volts = hyst_q[15:0];
    wire [15:0] hyst_fraction = hyst_q[31:16];

    // source table, dense order matches src_lookup
    scope_pkg::sample_t src [`NUM_SRC];
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_two
            assign src[i] = SIGIN_IN[16*i +: 16];
            assign src[2+i] = trig_s[i] ? `SAMPLE_HIGH : 16'h0000;
            assign src[8+i] = AUXIN_IN[16*i +: 16];
            assign src[46+i] = BOXCAR_IN[16*i +: 16];
            assign src[48+i] = ARITH_CART_IN[16*i +: 16];
        end
        for (i = 0; i < 4; i++) begin : g_four
            assign src[4+i] = AUXOUT_IN[16*i +: 16];
            assign src[42+i] = LOOP_VALUE_IN[16*i +: 16];
            assign src[51+i] = LOOP_SHIFT_IN[16*i +: 16];
            assign src[55+i] = AWG_MARKER_IN[i] ? `SAMPLE_HIGH : 16'h0000;
            assign src[59+i] = AWG_TRIG_IN[i] ? `SAMPLE_HIGH : 16'h0000;
            assign src[63+i] = LOOP_ERROR_IN[16*i +: 16];
        end
        for (i = 0; i < 8; i++) begin : g_eight
            assign src[10+i] = DEMOD_X_IN[16*i +: 16];
            assign src[18+i] = DEMOD_Y_IN[16*i +: 16];
            assign src[26+i] = DEMOD_R_IN[16*i +: 16];
            assign src[34+i] = DEMOD_PHASE_IN[16*i +: 16];
        end
    endgenerate
    assign src[50] = ARITH_POLAR_IN;

    // span and offset from the configured limits
    logic signed [16:0] span [2];
    logic signed [15:0] offs [2];
    scope_pkg::sample_t raw [2];
    scope_pkg::sample_t out_q [2];
    logic signed [31:0] acc_q [2];
    logic pend_q [2];
    logic taken [2];
    logic ovf_hit [2];
    logic [14:0] cnt_q;
    wire [14:0] cnt_last = 15'((16'h0001 << rate) - 16'h0001);
    wire emit = SAMPLE_VALID_IN && (cnt_q == cnt_last);

    generate
        for (i = 0; i < 2; i++) begin : g_ch
            wire signed [16:0] fl = {lim_q[i][15], lim_q[i][15:0]};
            wire signed [16:0] cl = {lim_q[i][31], lim_q[i][31:16]};
            wire signed [16:0] sum2 = fl + cl;
            assign span[i] = cl - fl;
            assign offs[i] = sum2[16:1];
            wire [8:0] sel = src_lookup(code_q[i]);
            // option-only sources read zero without the digitizer option
            assign raw[i] = (sel[8] && (!sel[7] || option)) ? src[sel[6:0]] : 16'h0000;
            wire signed [31:0] sum = acc_q[i] + {{16{raw[i][15]}}, raw[i]};
            wire signed [31:0] mean = sum >>> rate;
            wire drop = ctrl_q[`CTRL_DROP+i];
            wire push_req = emit && ctrl_q[`CTRL_STREN+i] && option;
            assign ovf_hit[i] = push_req && pend_q[i] && !taken[i];
            always_ff @(posedge CLK_SYS_IN) begin
                if (SYS_RST_IN) begin
                    acc_q[i] <= 32'h0000_0000;
                    out_q[i] <= 16'h0000;
                    pend_q[i] <= 1'b0;
                end else begin
                    if (SAMPLE_VALID_IN) begin
                        acc_q[i] <= emit ? 32'h0000_0000 : sum;
                    end
                    if (emit) begin
                        out_q[i] <= drop ? raw[i] : mean[15:0];
                    end
                    // a new word wins over the push that takes the old one
                    pend_q[i] <= push_req || (pend_q[i] && !taken[i]);
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            cnt_q <= 15'h0000;
        end else if (SAMPLE_VALID_IN) begin
            cnt_q <= emit ? 15'h0000 : cnt_q + 15'h0001;
        end
    end

    // stream fifo; a full fifo stalls the pending words
    stream_if #(.W(`WORD_W)) wr_s ();
    stream_if #(.W(`WORD_W)) rd_s ();
    wire push_ch = !pend_q[0];
    assign wr_s.valid = pend_q[0] || pend_q[1];
    assign wr_s.data = {push_ch, push_ch ? out_q[1] : out_q[0]};
    assign taken[0] = wr_s.valid && wr_s.ready && !push_ch;
    assign taken[1] = wr_s.valid && wr_s.ready && push_ch;

    scope_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk_in(CLK_SYS_IN),
        .rst_in(SYS_RST_IN),
        .wr(wr_s),
        .rd(rd_s)
    );
    assign rd_s.ready = access && !PWRITE_IN && (PADDR_IN == `OFS_STREAM);

    // trigger on channel 0's selected sample
    scope_pkg::arm_state_t arm_q;
    logic prev_above_q;
    logic trig_q;
    wire scope_pkg::sample_t cur = raw[0];
    wire above = cur >= $signed(level_q);
    wire [16:0] span_pos = span[0][16] ? 17'h00000 : span[0];
    wire [32:0] prod = hyst_fraction * span_pos;
    wire [24:0] rel = prod[32:`FRAC_SHIFT];
    wire [16:0] rel_sat = (|rel[24:17]) ? 17'h1FFFF : rel[16:0];
    wire [16:0] hyst_amt = hyst_kind ? rel_sat : {1'b0, hyst_volts};
    wire signed [18:0] lvl19 = {{3{level_q[15]}}, level_q};
    wire signed [18:0] cur19 = {{3{cur[15]}}, cur};
    wire signed [18:0] lo_th = lvl19 - $signed({2'b00, hyst_amt});
    wire signed [18:0] hi_th = lvl19 + $signed({2'b00, hyst_amt});
    wire rise_hit = above && !prev_above_q;
    wire fall_hit = !above && prev_above_q;
    // edge selection fixes both the trigger edge and the hysteresis sign
    wire edge_hit = (edge_sel == scope_pkg::EDGE_RISE) ? rise_hit :
                    (edge_sel == scope_pkg::EDGE_FALL) ? fall_hit :
                    (edge_sel == scope_pkg::EDGE_BOTH) ? (rise_hit || fall_hit) : 1'b0;
    wire rearm = (edge_sel == scope_pkg::EDGE_RISE) ? (cur19 <= lo_th) :
                 (edge_sel == scope_pkg::EDGE_FALL) ? (cur19 >= hi_th) :
                 (edge_sel == scope_pkg::EDGE_BOTH) ? (cur19 <= lo_th || cur19 >= hi_th) : 1'b1;
    wire gate_lvl = trig_s[{1'b1, gate_sel[1]}] ^ gate_sel[0];
    // gating needs the digitizer option; without it triggers pass ungated
    wire gate_open = !(gate_en && option) || gate_lvl;
    wire fire = SAMPLE_VALID_IN && (arm_q == scope_pkg::ARM_ST) && edge_hit && gate_open;
    wire hyst_off = (hyst_amt == 17'h00000);

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            arm_q <= scope_pkg::ARM_ST;
            prev_above_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            trig_q <= fire;
            prev_above_q <= SAMPLE_VALID_IN ? above : prev_above_q;
            case (arm_q)
                scope_pkg::ARM_ST: arm_q <= (fire && !hyst_off) ? scope_pkg::HOLD_ST : scope_pkg::ARM_ST;
                scope_pkg::HOLD_ST: arm_q <= (SAMPLE_VALID_IN && rearm) ? scope_pkg::ARM_ST : scope_pkg::HOLD_ST;
                default: arm_q <= scope_pkg::ARM_ST;
            endcase
        end
    end
    assign TRIG_OUT = trig_q;
    assign TRIG_ARMED_OUT = (arm_q == scope_pkg::ARM_ST);

    // register writes
    wire hit_ctrl = PADDR_IN == `OFS_CTRL;
    wire hit_status = PADDR_IN == `OFS_STATUS;
    wire [31:0] level_wr = strb_merge({16'h0000, level_q}, PWDATA_IN, PSTRB_IN);
    wire [31:0] status = {27'h000_0000, ovf_q, rd_s.valid, option, gate_open, TRIG_ARMED_OUT};
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            ctrl_q <= `RST_CTRL;
            level_q <= `RST_LEVEL;
            hyst_q <= `RST_HYST;
            code_q[0] <= `RST_SRC;
            code_q[1] <= `RST_SRC;
            lim_q[0] <= `RST_LIM;
            lim_q[1] <= `RST_LIM;
        end else if (wr_en) begin
            ctrl_q <= hit_ctrl ? strb_merge(ctrl_q, PWDATA_IN, PSTRB_IN) : ctrl_q;
            level_q <= (PADDR_IN == `OFS_LEVEL) ? level_wr[15:0] : level_q;
            hyst_q <= (PADDR_IN == `OFS_HYST) ? strb_merge(hyst_q, PWDATA_IN, PSTRB_IN) : hyst_q;
            code_q[0] <= ((PADDR_IN == `OFS_SRC0) && PSTRB_IN[0]) ? PWDATA_IN[7:0] : code_q[0];
            code_q[1] <= ((PADDR_IN == `OFS_SRC1) && PSTRB_IN[0]) ? PWDATA_IN[7:0] : code_q[1];
            lim_q[0] <= (PADDR_IN == `OFS_LIM0) ? strb_merge(lim_q[0], PWDATA_IN, PSTRB_IN) : lim_q[0];
            lim_q[1] <= (PADDR_IN == `OFS_LIM1) ? strb_merge(lim_q[1], PWDATA_IN, PSTRB_IN) : lim_q[1];
        end
    end

    // overflow is sticky, write one to clear; a new loss wins over the clear
    wire ovf_clr = wr_en && hit_status && PSTRB_IN[0] && PWDATA_IN[`STAT_OVF];
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_hit[0] || ovf_hit[1] || (ovf_q && !ovf_clr);
        end
    end

    // read data is captured in the setup cycle so it comes from a flip-flop
    // an empty fifo reads as zero rather than the stale word left in its read register
    wire [31:0] stream_word = rd_s.valid ? {1'b1, 14'h0000, rd_s.data} : 32'h0000_0000;
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_q :
        (PADDR_IN == `OFS_LEVEL) ? {16'h0000, level_q} :
        (PADDR_IN == `OFS_HYST) ? hyst_q :
        (PADDR_IN == `OFS_SRC0) ? {24'h00_0000, code_q[0]} :
        (PADDR_IN == `OFS_SRC1) ? {24'h00_0000, code_q[1]} :
        (PADDR_IN == `OFS_LIM0) ? lim_q[0] :
        (PADDR_IN == `OFS_LIM1) ? lim_q[1] :
        (PADDR_IN == `OFS_SPAN0) ? {{15{span[0][16]}}, span[0]} :
        (PADDR_IN == `OFS_OFFS0) ? {{16{offs[0][15]}}, offs[0]} :
        (PADDR_IN == `OFS_SPAN1) ? {{15{span[1][16]}}, span[1]} :
        (PADDR_IN == `OFS_OFFS1) ? {{16{offs[1][15]}}, offs[1]} :
        hit_status ? status :
        (PADDR_IN == `OFS_STREAM) ? stream_word : 32'h0000_0000;
    wire mapped = (PADDR_IN[1:0] == 2'b00) && (PADDR_IN <= `OFS_STREAM);

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= rd_mux;
            err_q <= !mapped;
        end
    end
    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access && err_q;
endmodule : scope_trigger_channel_select

// ==== scope_host_model.sv ====
// scope_host_model: apb master standing in for the host software
// assumes: one clock; the slave may stretch the access phase
`timescale 1ns/1ns
module scope_host_model (
    input wire logic clk_in,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    output logic [11:0] paddr_out,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [31:0] pwdata_out,
    output logic [3:0] pstrb_out
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0000_0000;
        pstrb_out = 4'h0;
    end
    // callers pass source codes unchecked; t_mux also writes the unlisted code 10
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] r, output logic e);
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        pstrb_out <= s;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        r = prdata_in;
        e = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
    endtask : xfer
endmodule : scope_host_model

// ==== scope_trigger_channel_select_chk.sv ====
// scope_trigger_channel_select_chk: port-level checks on bus answers and the trigger
// assumes: bound to the top module; one clock, synchronous reset
`timescale 1ns/1ns
module scope_trigger_channel_select_chk (
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic SAMPLE_VALID_IN,
    input wire logic TRIG_OUT,
    input wire logic TRIG_ARMED_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    wire bad_addr = (PADDR_IN > 12'h030) || (PADDR_IN[1:0] != 2'h0);
    ready_always_a: assert property (PREADY_OUT) else $error("pready low");
    err_phase_a: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN) else $error("error outside access");
    err_decode_a: assert property (PSEL_IN && PENABLE_IN |-> PSLVERR_OUT == bad_addr)
        else $error("error flag wrong");
    bad_read_a: assert property (PSEL_IN && !PENABLE_IN && !PWRITE_IN && bad_addr |=> PRDATA_OUT == 32'h0000_0000)
        else $error("unmapped read not zero");
    fire_cause_a: assert property (TRIG_OUT |-> $past(SAMPLE_VALID_IN) && $past(TRIG_ARMED_OUT))
        else $error("trigger without armed strobe");
    disarm_fire_a: assert property ($fell(TRIG_ARMED_OUT) |-> TRIG_OUT) else $error("disarm without trigger");
    rearm_strobe_a: assert property ($rose(TRIG_ARMED_OUT) && !$past(SYS_RST_IN) |-> $past(SAMPLE_VALID_IN))
        else $error("rearm without strobe");
    reset_idle_a: assert property (disable iff (1'b0) SYS_RST_IN |=> TRIG_ARMED_OUT && !TRIG_OUT)
        else $error("reset state wrong");
endmodule : scope_trigger_channel_select_chk
bind scope_trigger_channel_select scope_trigger_channel_select_chk u_chk(.CLK_SYS_IN(CLK_SYS_IN),
    .SYS_RST_IN(SYS_RST_IN), .PADDR_IN(PADDR_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .TRIG_OUT(TRIG_OUT), .TRIG_ARMED_OUT(TRIG_ARMED_OUT));

// ==== tb_top.sv ====
// tb_top: directed scenarios for the scope front end
// assumes: host model and checker compiled first; option strap held present except for one status read in t_fifo
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, rst = 1'b1, sv = 1'b0, opt = 1'b1, pready, perr, psel, pen, pwr, trig, armed, er;
    logic [31:0] sig = 32'h0000_0000, prdata, pwdata, rd;
    logic [3:0] pins = 4'h1, mrk = 4'h9, atr = 4'h0, pstrb;
    logic [11:0] paddr;
    logic [63:0] ax = {4{16'h2000}}, lv = {16'h0103, {3{16'h0100}}}, ls = {4{16'h0200}}, le = {16'h0303, {3{16'h0300}}};
    logic [127:0] dx = {16'h4007, {7{16'h4000}}}, dy = {8{16'h5000}}, dr = {8{16'h6000}}, dp = {8{16'h7000}};
    logic [31:0] ai = {2{16'h3000}}, bx = {16'h0401, 16'h0400}, ca = {2{16'h0500}};
    logic [15:0] po = 16'h0600;
    int err_total = 0, checks = 0, cyc = 0;
    localparam logic [7:0] mux_code [18] = '{0, 1, 2, 4, 8, 10, 23, 32, 48, 64, 83, 97, 112, 128, 144, 179, 192, 211};
    localparam logic [15:0] mux_exp [18] = '{16'h1000, 16'h1001, 16'h7FFF, 16'h2000, 16'h3000, 16'h0000, 16'h4007,
        16'h5000, 16'h6000, 16'h7000, 16'h0103, 16'h0401, 16'h0500, 16'h0600, 16'h0200, 16'h7FFF, 16'h0000, 16'h0303};
    always #5 clk = ~clk;
    scope_host_model u_host(.clk_in(clk), .prdata_in(prdata), .pready_in(pready), .pslverr_in(perr),
        .paddr_out(paddr), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .pwdata_out(pwdata), .pstrb_out(pstrb));
    scope_trigger_channel_select u_dut(.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .PADDR_IN(paddr), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(perr), .SAMPLE_VALID_IN(sv), .SIGIN_IN(sig), .TRIG_PIN_IN(pins),
        .AUXOUT_IN(ax), .AUXIN_IN(ai), .DEMOD_X_IN(dx), .DEMOD_Y_IN(dy), .DEMOD_R_IN(dr), .DEMOD_PHASE_IN(dp),
        .LOOP_VALUE_IN(lv), .LOOP_SHIFT_IN(ls), .LOOP_ERROR_IN(le), .BOXCAR_IN(bx), .ARITH_CART_IN(ca),
        .ARITH_POLAR_IN(po), .AWG_MARKER_IN(mrk), .AWG_TRIG_IN(atr), .DIGITIZER_OPTION_IN(opt),
        .TRIG_OUT(trig), .TRIG_ARMED_OUT(armed));
    task automatic report_and_stop();
        if (err_total == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        u_host.xfer(1'b1, a, d, s, rd, er);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        u_host.xfer(1'b0, a, 32'h0000_0000, 4'h0, rd, er);
        chk(rd, exp);
    endtask : rdc
    task automatic strobe(input logic [31:0] s, input logic t);
        @(posedge clk);
        sig <= s;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        #1;
        chk({31'h0, trig}, {31'h0, t});
    endtask : strobe
    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask : reset_dut
    task automatic t_regs();
        rdc(12'h014, 32'h7FFF_8000);
        wr(12'h014, 32'h0030_0010);
        wr(12'h014, 32'hFFFF_FFFF, 4'h0);
        rdc(12'h01C, 32'h0000_0020);
        rdc(12'h020, 32'h0000_0020);
        rdc(12'h034, 32'h0000_0000);
        chk({31'h0, er}, 32'h1);
    endtask : t_regs
    task automatic t_mux();
        wr(12'h000, 32'h0000_1000);
        for (int i = 0; i < 18; i++) begin
            wr(12'h00C, {24'h0, mux_code[i]}, 4'h1);
            strobe(32'h1001_1000, 1'b0);
            @(posedge clk);
            rdc(12'h030, {16'h8000, mux_exp[i]});
        end
    endtask : t_mux
    task automatic t_avg();
        reset_dut();
        wr(12'h000, 32'h0000_B200);
        wr(12'h010, 32'h0000_0001, 4'h1);
        strobe(32'h0001_FFFC, 1'b0);
        strobe(32'h0002_FFF8, 1'b0);
        strobe(32'h0003_FFF4, 1'b0);
        strobe(32'h0004_FFF1, 1'b0);
        rdc(12'h030, 32'h8000_FFF6);
        rdc(12'h030, 32'h8001_0004);
    endtask : t_avg
    task automatic t_fifo();
        reset_dut();
        wr(12'h000, 32'h0000_1000);
        for (int i = 1; i <= 10; i++) strobe(i, 1'b0);
        rdc(12'h02C, 32'h0000_001F);
        for (int i = 1; i <= 9; i++) rdc(12'h030, 32'h8000_0000 | (i == 9 ? 10 : i));
        rdc(12'h030, 32'h0000_0000);
        wr(12'h02C, 32'h0000_0010, 4'h1);
        rdc(12'h02C, 32'h0000_0007);
        opt <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(12'h02C, 32'h0000_0003);
        opt <= 1'b1;
    endtask : t_fifo
    task automatic t_trig_abs();
        reset_dut();
        wr(12'h004, 32'h0000_0100);
        wr(12'h008, 32'h0000_0040);
        wr(12'h000, 32'h0000_0008);
        strobe(32'h0, 1'b0);
        strobe(32'h200, 1'b1);
        strobe(32'hF0, 1'b0);
        strobe(32'h200, 1'b0);
        strobe(32'h0, 1'b0);
        chk({31'h0, armed}, 32'h1);
        // gate pins 3 and 4 sit low, so only the two low-level selections open it
        for (int s = 0; s < 4; s++) begin
            wr(12'h000, 32'h9 | (s << 1));
            strobe(32'h0, 1'b0);
            strobe(32'h200, s[0]);
        end
    endtask : t_trig_abs
    task automatic t_trig_rel();
        reset_dut();
        wr(12'h004, 32'h0000_0100);
        wr(12'h008, 32'h0200_0000);
        wr(12'h014, 32'h0020_0000);
        wr(12'h000, 32'h0000_0030);
        strobe(32'h200, 1'b0);
        strobe(32'h0, 1'b1);
        strobe(32'h130, 1'b0);
        chk({31'h0, armed}, 32'h0);
        strobe(32'h140, 1'b0);
        chk({31'h0, armed}, 32'h1);
    endtask : t_trig_rel
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_mux();
        t_avg();
        t_fifo();
        t_trig_abs();
        t_trig_rel();
        report_and_stop();
    end
endmodule : tb_top
